// ==== esc_pkg.sv ====
// Behaviour
// - Save-support flag set: legacy save/restore also moves vector and SIMD status state.
// - Save-support flag clear: non-exempt SIMD instructions raise invalid-opcode fault.
// - Save-support flag clear: legacy save/restore still moves float and packed-integer state.
// - Unmasked SIMD float exception: SIMD fault if support flag set, else invalid-opcode.
// - Bit 13 enables virtualization, bit 14 enables safer mode.
// - State-save enable shows in query leaf 1 bit 27 and opens mask access.
// - Mask read and write are allowed only while bit 18 is one.
// - Priority threshold 0 leaves all interrupts enabled, 15 blocks them all.
// - Task priority register is reachable only in 64-bit mode on 64-bit parts.
// - Feature query reports each implemented control flag, except counter read enable.
// - Extended control registers exist exactly when query leaf 1 bit 26 is one.
// - Mask bit 63 is reserved and never a state set.
// - Mask bit 0 always one; writing it zero faults and leaves mask unchanged.
// - Mask bit 1 covers vector and status registers: sixteen in 64-bit mode, else eight.
// - Writing any mask bit reported unsupported raises general-protection fault.
// - Extended save stores only subsets enabled in mask and in the save mask.
// - Reset clears the mask except bit 0, which becomes one.
package esc_pkg;
	localparam int BIT_LEGACY_SAVE = 9;
	localparam int BIT_SIMD_EXC = 10;
	localparam int BIT_VIRT = 13;
	localparam int BIT_SAFER = 14;
	localparam int BIT_STATE_SAVE = 18;
	localparam int BIT_COUNTER_READ = 8;
	localparam int QBIT_EXT_STATE = 26;
	localparam int QBIT_OS_STATE_SAVE = 27;
	localparam int MASK_RESERVED_BIT = 63;
	localparam logic [31:0] EXT_CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] EXT_CTRL_IMPL = 32'h0004_67FF;
	localparam logic [3:0] PRIO_RESET = 4'h0;
	localparam logic [3:0] PRIO_ALL = 4'hF;
	localparam logic [63:0] MASK_RESET = 64'h0000_0000_0000_0001;
	localparam logic [63:0] MASK_SUPPORTED = 64'h0000_0000_0000_0003;
	localparam logic [4:0] VEC_COUNT_LONG = 5'h10;
	localparam logic [4:0] VEC_COUNT_LEGACY = 5'h08;
	typedef enum logic [3:0] {
		OP_CR_READ = 4'h0,
		OP_CR_WRITE = 4'h1,
		OP_MASK_READ = 4'h2,
		OP_MASK_WRITE = 4'h3,
		OP_QUERY = 4'h4,
		OP_SIMD_EXEC = 4'h5,
		OP_SIMD_FPX = 4'h6,
		OP_LEGACY_SAVE = 4'h7,
		OP_EXT_SAVE = 4'h8
	} esc_op_e;
	typedef enum logic [1:0] {
		SEL_EXT_CTRL = 2'h0,
		SEL_TASK_PRIO = 2'h1,
		SEL_LEAF1 = 2'h2,
		SEL_LEAF0D = 2'h3
	} esc_sel_e;
	typedef struct packed {
		logic [31:0] ext_ctrl;
		logic [3:0] prio;
		logic [63:0] mask;
		logic resp_valid;
		logic [63:0] resp_data;
		logic fault_ud;
		logic fault_gp;
		logic fault_xf;
		logic int_blocked;
		logic [4:0] vec_count;
	} esc_state_s;
endpackage : esc_pkg

// ==== esc_mask_check.sv ====
`timescale 1ns/10ps
`default_nettype none
module esc_mask_check
	import esc_pkg::*;
#(
	parameter logic [63:0] SUPPORTED = MASK_SUPPORTED
)(
	input wire logic [63:0] i_wdata,
	output logic o_bad
);
	always_comb
	begin
		o_bad = 1'b0;
		if (!i_wdata[0])
			o_bad = 1'b1;
		if (i_wdata[MASK_RESERVED_BIT])
			o_bad = 1'b1;
		if (|(i_wdata & ~SUPPORTED))
			o_bad = 1'b1;
	end
endmodule : esc_mask_check
`default_nettype wire

// ==== esc_fault_eval.sv ====
`timescale 1ns/10ps
`default_nettype none
module esc_fault_eval
	import esc_pkg::*;
#(
	parameter logic [31:0] IMPL = EXT_CTRL_IMPL,
	parameter bit HAS_EXT_STATE = 1'b1,
	parameter bit HAS_LONG = 1'b1
)(
	input wire esc_op_e i_op,
	input wire esc_sel_e i_sel,
	input wire logic i_priv,
	input wire logic i_long_mode,
	input wire logic i_exempt,
	input wire logic [31:0] i_ext_ctrl,
	input wire logic [63:0] i_wdata,
	input wire logic i_mask_bad,
	output logic o_ud,
	output logic o_gp,
	output logic o_xf
);
	logic xcr_ok;
	always_comb
	begin
		o_ud = 1'b0;
		o_gp = 1'b0;
		o_xf = 1'b0;
		xcr_ok = HAS_EXT_STATE && i_ext_ctrl[BIT_STATE_SAVE];
		case (i_op)
			OP_CR_READ, OP_CR_WRITE:
			begin
				if (i_sel == SEL_TASK_PRIO && !(HAS_LONG && i_long_mode))
					o_ud = 1'b1;
				else if (i_sel != SEL_EXT_CTRL && i_sel != SEL_TASK_PRIO)
					o_ud = 1'b1;
				else if (!i_priv)
					o_gp = 1'b1;
				else if (i_op == OP_CR_WRITE && i_sel == SEL_EXT_CTRL)
					o_gp = |(i_wdata[31:0] & ~IMPL) || |i_wdata[63:32];
				else if (i_op == OP_CR_WRITE)
					o_gp = |i_wdata[63:4];
			end
			OP_MASK_READ, OP_EXT_SAVE:
				o_ud = !xcr_ok;
			OP_MASK_WRITE:
			begin
				if (!xcr_ok)
					o_ud = 1'b1;
				else if (!i_priv || i_mask_bad)
					o_gp = 1'b1;
			end
			OP_SIMD_EXEC:
				o_ud = !i_exempt && !i_ext_ctrl[BIT_LEGACY_SAVE];
			OP_SIMD_FPX:
			begin
				o_xf = i_ext_ctrl[BIT_SIMD_EXC];
				o_ud = !i_ext_ctrl[BIT_SIMD_EXC];
			end
			default:
			begin
				o_ud = 1'b0;
			end
		endcase
	end
endmodule : esc_fault_eval
`default_nettype wire

// ==== esc_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none
module esc_ctrl
	import esc_pkg::*;
#(
	parameter logic [31:0] IMPL = EXT_CTRL_IMPL,
	parameter logic [63:0] SUPPORTED = MASK_SUPPORTED,
	parameter bit HAS_EXT_STATE = 1'b1,
	parameter bit HAS_LONG = 1'b1
)(
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_req_valid,
	input wire esc_op_e i_req_op,
	input wire esc_sel_e i_req_sel,
	input wire logic [63:0] i_req_data,
	input wire logic i_priv,
	input wire logic i_long_mode,
	input wire logic i_exempt,
	input wire logic [3:0] i_int_class,
	output logic o_resp_valid,
	output logic [63:0] o_resp_data,
	output logic o_fault_ud,
	output logic o_fault_gp,
	output logic o_fault_xf,
	output logic o_os_legacy_save_support,
	output logic o_simd_exception_support,
	output logic o_virtualization_enable,
	output logic o_safer_mode_enable,
	output logic o_os_state_save_enable,
	output logic [3:0] o_priority_threshold,
	output logic [63:0] o_state_enable_mask,
	output logic o_int_blocked,
	output logic [4:0] o_vec_count
);
	esc_state_s r;
	esc_state_s next_r;
	logic mask_bad;
	logic f_ud;
	logic f_gp;
	logic f_xf;
	logic [63:0] leaf1;

	esc_mask_check #(
		.SUPPORTED(SUPPORTED)
	) u_mask_check (
		.i_wdata(i_req_data),
		.o_bad(mask_bad)
	);

	esc_fault_eval #(
		.IMPL(IMPL),
		.HAS_EXT_STATE(HAS_EXT_STATE),
		.HAS_LONG(HAS_LONG)
	) u_fault_eval (
		.i_op(i_req_op),
		.i_sel(i_req_sel),
		.i_priv(i_priv),
		.i_long_mode(i_long_mode),
		.i_exempt(i_exempt),
		.i_ext_ctrl(r.ext_ctrl),
		.i_wdata(i_req_data),
		.i_mask_bad(mask_bad),
		.o_ud(f_ud),
		.o_gp(f_gp),
		.o_xf(f_xf)
	);

	always_comb
	begin
		next_r = r;
		leaf1 = 64'h0;
		leaf1[QBIT_EXT_STATE] = HAS_EXT_STATE;
		leaf1[QBIT_OS_STATE_SAVE] = r.ext_ctrl[BIT_STATE_SAVE];
		next_r.resp_valid = i_req_valid;
		next_r.resp_data = 64'h0;
		next_r.fault_ud = i_req_valid && f_ud;
		next_r.fault_gp = i_req_valid && f_gp;
		next_r.fault_xf = i_req_valid && f_xf;
		next_r.int_blocked = (r.prio != PRIO_RESET) && (i_int_class <= r.prio);
		next_r.vec_count = i_long_mode ? VEC_COUNT_LONG : VEC_COUNT_LEGACY;
		if (i_req_valid && !f_ud && !f_gp && !f_xf)
		begin
			case (i_req_op)
				OP_CR_READ:
				begin
					if (i_req_sel == SEL_EXT_CTRL)
						next_r.resp_data = {32'h0, r.ext_ctrl};
					else
						next_r.resp_data = {60'h0, r.prio};
				end
				OP_CR_WRITE:
				begin
					if (i_req_sel == SEL_EXT_CTRL)
						next_r.ext_ctrl = i_req_data[31:0] & IMPL;
					else
						next_r.prio = i_req_data[3:0];
				end
				OP_MASK_READ:
					next_r.resp_data = r.mask;
				OP_MASK_WRITE:
					next_r.mask = i_req_data;
				OP_QUERY:
				begin
					if (i_req_sel == SEL_LEAF1)
						next_r.resp_data = leaf1;
					else if (i_req_sel == SEL_LEAF0D)
						next_r.resp_data = SUPPORTED;
					else
					begin
						next_r.resp_data = {32'h0, IMPL};
						next_r.resp_data[BIT_COUNTER_READ] = 1'b0;
					end
				end
				OP_LEGACY_SAVE:
				begin
					next_r.resp_data[0] = 1'b1;
					next_r.resp_data[1] = r.ext_ctrl[BIT_LEGACY_SAVE];
				end
				OP_EXT_SAVE:
					next_r.resp_data = r.mask & i_req_data;
				default:
				begin
					next_r.resp_data = 64'h0;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			r.ext_ctrl <= EXT_CTRL_RESET;
			r.prio <= PRIO_RESET;
			r.mask <= MASK_RESET;
			r.resp_valid <= 1'b0;
			r.resp_data <= 64'h0;
			r.fault_ud <= 1'b0;
			r.fault_gp <= 1'b0;
			r.fault_xf <= 1'b0;
			r.int_blocked <= 1'b0;
			r.vec_count <= VEC_COUNT_LEGACY;
		end
		else
			r <= next_r;
	end

	assign o_resp_valid = r.resp_valid;
	assign o_resp_data = r.resp_data;
	assign o_fault_ud = r.fault_ud;
	assign o_fault_gp = r.fault_gp;
	assign o_fault_xf = r.fault_xf;
	assign o_os_legacy_save_support = r.ext_ctrl[BIT_LEGACY_SAVE];
	assign o_simd_exception_support = r.ext_ctrl[BIT_SIMD_EXC];
	assign o_virtualization_enable = r.ext_ctrl[BIT_VIRT];
	assign o_safer_mode_enable = r.ext_ctrl[BIT_SAFER];
	assign o_os_state_save_enable = r.ext_ctrl[BIT_STATE_SAVE];
	assign o_priority_threshold = r.prio;
	assign o_state_enable_mask = r.mask;
	assign o_int_blocked = r.int_blocked;
	assign o_vec_count = r.vec_count;

	sequence s_req(esc_op_e op);
		i_req_valid && i_req_op == op;
	endsequence

	sequence s_gp_answer;
		o_resp_valid && o_fault_gp && !o_fault_ud;
	endsequence

	property p_mask_bit0;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		r.mask[0] && !r.mask[MASK_RESERVED_BIT];
	endproperty
	a_mask_bit0: assert property (p_mask_bit0)
		else $error("mask bit 0 clear or bit 63 set");

	property p_mask_zero_write;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		s_req(OP_MASK_WRITE) ##0 (r.ext_ctrl[BIT_STATE_SAVE] && !i_req_data[0])
		|=> s_gp_answer ##0 $stable(r.mask);
	endproperty
	a_mask_zero_write: assert property (p_mask_zero_write)
		else $error("clearing mask bit 0 did not fault or changed mask");

	property p_mask_unsupported;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		s_req(OP_MASK_WRITE) ##0 r.ext_ctrl[BIT_STATE_SAVE] ##0 (|(i_req_data & ~SUPPORTED))
		|=> s_gp_answer ##0 ((r.mask & ~SUPPORTED) == 64'h0);
	endproperty
	a_mask_unsupported: assert property (p_mask_unsupported)
		else $error("unsupported mask bit accepted");

	property p_mask_gate;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		(s_req(OP_MASK_READ) or s_req(OP_MASK_WRITE)) ##0 !r.ext_ctrl[BIT_STATE_SAVE]
		|=> o_fault_ud && $stable(r.mask) && o_resp_data == 64'h0;
	endproperty
	a_mask_gate: assert property (p_mask_gate)
		else $error("mask access allowed with state-save disabled");

	property p_simd_ud;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		s_req(OP_SIMD_EXEC) ##0 !i_exempt
		|=> o_fault_ud == !$past(r.ext_ctrl[BIT_LEGACY_SAVE]);
	endproperty
	a_simd_ud: assert property (p_simd_ud)
		else $error("SIMD execution gating wrong");

	property p_fpx;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		s_req(OP_SIMD_FPX)
		|=> o_resp_valid && (o_fault_xf != o_fault_ud) && (o_fault_xf == $past(r.ext_ctrl[BIT_SIMD_EXC]));
	endproperty
	a_fpx: assert property (p_fpx)
		else $error("SIMD float exception routed wrongly");

	property p_prio_mode;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		(s_req(OP_CR_READ) or s_req(OP_CR_WRITE)) ##0 (i_req_sel == SEL_TASK_PRIO && !i_long_mode)
		|=> o_fault_ud && $stable(r.prio);
	endproperty
	a_prio_mode: assert property (p_prio_mode)
		else $error("task priority reached outside 64-bit mode");

	property p_prio_zero;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		r.prio == PRIO_RESET |=> !o_int_blocked;
	endproperty
	a_prio_zero: assert property (p_prio_zero)
		else $error("interrupt blocked at threshold 0");

	property p_prio_all;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		r.prio == PRIO_ALL |=> o_int_blocked || $past(i_int_class) == 4'h0;
	endproperty
	a_prio_all: assert property (p_prio_all)
		else $error("interrupt passed at threshold 15");

	property p_query_leaf1;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		s_req(OP_QUERY) ##0 i_req_sel == SEL_LEAF1
		|=> o_resp_data[QBIT_OS_STATE_SAVE] == $past(r.ext_ctrl[BIT_STATE_SAVE])
			&& o_resp_data[QBIT_EXT_STATE] == HAS_EXT_STATE;
	endproperty
	a_query_leaf1: assert property (p_query_leaf1)
		else $error("leaf 1 report wrong");

	property p_ext_save;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		s_req(OP_EXT_SAVE)
		|=> (o_resp_data & ~($past(r.mask) & $past(i_req_data))) == 64'h0;
	endproperty
	a_ext_save: assert property (p_ext_save)
		else $error("extended save stored disabled state");

	property p_legacy_save;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		s_req(OP_LEGACY_SAVE)
		|=> o_resp_data[0] && o_resp_data[1] == $past(r.ext_ctrl[BIT_LEGACY_SAVE]);
	endproperty
	a_legacy_save: assert property (p_legacy_save)
		else $error("legacy save content wrong");

	// Sampled reset keeps the release edge out: the flops still take reset there
	property p_vec_count;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		i_long_mode && i_reset_n ##1 1'b1 |-> o_vec_count == VEC_COUNT_LONG;
	endproperty
	a_vec_count: assert property (p_vec_count)
		else $error("vector count wrong in 64-bit mode");

	property p_vec_legacy;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		!i_long_mode && i_reset_n |=> o_vec_count == VEC_COUNT_LEGACY;
	endproperty
	a_vec_legacy: assert property (p_vec_legacy)
		else $error("vector count wrong outside 64-bit mode");

	property p_reset_values;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		!$past(i_reset_n) |-> r.mask == MASK_RESET && r.ext_ctrl == EXT_CTRL_RESET
			&& r.prio == PRIO_RESET;
	endproperty
	a_reset_values: assert property (p_reset_values)
		else $error("state after reset wrong");

	property p_legacy_base;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		s_req(OP_LEGACY_SAVE) ##0 !r.ext_ctrl[BIT_LEGACY_SAVE]
		|=> o_resp_valid && !o_fault_ud && o_resp_data[0] && !o_resp_data[1];
	endproperty
	a_legacy_base: assert property (p_legacy_base)
		else $error("legacy save without support flag wrong");

	property p_simd_exempt;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		s_req(OP_SIMD_EXEC) ##0 i_exempt
		|=> o_resp_valid && !o_fault_ud && !o_fault_gp;
	endproperty
	a_simd_exempt: assert property (p_simd_exempt)
		else $error("exempt instruction faulted");

	property p_ctrl_write;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		s_req(OP_CR_WRITE) ##0 (i_req_sel == SEL_EXT_CTRL && i_priv)
			##0 ((i_req_data & ~{32'h0, IMPL}) == 64'h0)
		|=> o_virtualization_enable == $past(i_req_data[BIT_VIRT])
			&& o_safer_mode_enable == $past(i_req_data[BIT_SAFER]);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write)
		else $error("virtualization or safer mode enable not taken");

	property p_prio_write;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		s_req(OP_CR_WRITE) ##0 (i_req_sel == SEL_TASK_PRIO && i_long_mode && i_priv)
			##0 (HAS_LONG && i_req_data[63:4] == 60'h0)
		|=> !o_fault_ud && o_priority_threshold == $past(i_req_data[3:0]);
	endproperty
	a_prio_write: assert property (p_prio_write)
		else $error("task priority write refused in 64-bit mode");

	property p_query_0d;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		s_req(OP_QUERY) ##0 i_req_sel == SEL_LEAF0D
		|=> o_resp_valid && o_resp_data == SUPPORTED;
	endproperty
	a_query_0d: assert property (p_query_0d)
		else $error("supported mask report wrong");

	property p_query_impl;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		s_req(OP_QUERY) ##0 (i_req_sel == SEL_EXT_CTRL || i_req_sel == SEL_TASK_PRIO)
		|=> o_resp_data == ({32'h0, IMPL} & ~(64'h1 << BIT_COUNTER_READ));
	endproperty
	a_query_impl: assert property (p_query_impl)
		else $error("implemented flag report wrong");

	property p_mask_accept;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		s_req(OP_MASK_WRITE) ##0 (r.ext_ctrl[BIT_STATE_SAVE] && i_priv && i_req_data[0])
			##0 ((i_req_data & ~SUPPORTED) == 64'h0)
		|=> !o_fault_gp && o_state_enable_mask == $past(i_req_data);
	endproperty
	a_mask_accept: assert property (p_mask_accept)
		else $error("legal mask write not taken");

	property p_flags_sw_only;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		!(i_req_valid && i_req_op == OP_CR_WRITE) |=> $stable(r.ext_ctrl);
	endproperty
	a_flags_sw_only: assert property (p_flags_sw_only)
		else $error("control flags changed without a write");
endmodule : esc_ctrl
`default_nettype wire

// ==== esc_ctrl_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module esc_ctrl_tb
	import esc_pkg::*;
();
	localparam logic [2:0] F_NONE = 3'h0;
	localparam logic [2:0] F_UD = 3'h4;
	localparam logic [2:0] F_GP = 3'h2;
	localparam logic [2:0] F_XF = 3'h1;
	logic i_ref_clk;
	logic i_reset_n;
	logic i_req_valid;
	esc_op_e i_req_op;
	esc_sel_e i_req_sel;
	logic [63:0] i_req_data;
	logic i_priv;
	logic i_long_mode;
	logic i_exempt;
	logic [3:0] i_int_class;
	logic o_resp_valid;
	logic [63:0] o_resp_data;
	logic o_fault_ud;
	logic o_fault_gp;
	logic o_fault_xf;
	logic o_os_legacy_save_support;
	logic o_simd_exception_support;
	logic o_virtualization_enable;
	logic o_safer_mode_enable;
	logic o_os_state_save_enable;
	logic [3:0] o_priority_threshold;
	logic [63:0] o_state_enable_mask;
	logic o_int_blocked;
	logic [4:0] o_vec_count;
	int bad_count;
	int comparisons;

	esc_ctrl u_esc_ctrl (
		.i_ref_clk(i_ref_clk),
		.i_reset_n(i_reset_n),
		.i_req_valid(i_req_valid),
		.i_req_op(i_req_op),
		.i_req_sel(i_req_sel),
		.i_req_data(i_req_data),
		.i_priv(i_priv),
		.i_long_mode(i_long_mode),
		.i_exempt(i_exempt),
		.i_int_class(i_int_class),
		.o_resp_valid(o_resp_valid),
		.o_resp_data(o_resp_data),
		.o_fault_ud(o_fault_ud),
		.o_fault_gp(o_fault_gp),
		.o_fault_xf(o_fault_xf),
		.o_os_legacy_save_support(o_os_legacy_save_support),
		.o_simd_exception_support(o_simd_exception_support),
		.o_virtualization_enable(o_virtualization_enable),
		.o_safer_mode_enable(o_safer_mode_enable),
		.o_os_state_save_enable(o_os_state_save_enable),
		.o_priority_threshold(o_priority_threshold),
		.o_state_enable_mask(o_state_enable_mask),
		.o_int_blocked(o_int_blocked),
		.o_vec_count(o_vec_count)
	);

	initial
	begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop

	// One request, answer checked in the single cycle it stands
	task automatic req(input esc_op_e op, input esc_sel_e sel, input logic [63:0] d,
		input logic [2:0] ef, input logic [63:0] ed);
		@(posedge i_ref_clk);
		i_req_valid <= 1'b1;
		i_req_op <= op;
		i_req_sel <= sel;
		i_req_data <= d;
		@(posedge i_ref_clk);
		i_req_valid <= 1'b0;
		#1;
		chk(64'(o_resp_valid), 64'h1);
		chk(64'({o_fault_ud, o_fault_gp, o_fault_xf}), 64'(ef));
		chk(o_resp_data, ed);
	endtask : req

	task automatic chk_flags(input logic [4:0] exp);
		chk(64'({o_os_legacy_save_support, o_simd_exception_support, o_virtualization_enable,
			o_safer_mode_enable, o_os_state_save_enable}), 64'(exp));
	endtask : chk_flags

	task automatic end_test(input string name);
		$display("test %s done", name);
	endtask : end_test

	initial
	begin
		#500us;
		$display("[FAIL] %0t run did not finish in time", $time);
		bad_count++;
		report_and_stop();
	end

	initial
	begin
		bad_count = 0;
		comparisons = 0;
		i_reset_n = 1'b0;
		i_req_valid = 1'b0;
		i_req_op = OP_CR_READ;
		i_req_sel = SEL_EXT_CTRL;
		i_req_data = 64'h0;
		i_priv = 1'b1;
		i_long_mode = 1'b0;
		i_exempt = 1'b0;
		i_int_class = 4'h0;
		repeat (12) @(posedge i_ref_clk);
		i_reset_n <= 1'b1;
		@(posedge i_ref_clk);
		#1;
		chk(o_state_enable_mask, 64'h1);
		chk_flags(5'h00);
		chk(64'(o_priority_threshold), 64'h0);
		chk(64'(o_vec_count), 64'h8);
		end_test("reset");
		// Everything disabled
		req(OP_MASK_READ, SEL_EXT_CTRL, 64'h0, F_UD, 64'h0);
		req(OP_MASK_WRITE, SEL_EXT_CTRL, 64'h3, F_UD, 64'h0);
		req(OP_QUERY, SEL_LEAF1, 64'h0, F_NONE, 64'h0400_0000);
		req(OP_SIMD_EXEC, SEL_EXT_CTRL, 64'h0, F_UD, 64'h0);
		req(OP_SIMD_FPX, SEL_EXT_CTRL, 64'h0, F_UD, 64'h0);
		req(OP_LEGACY_SAVE, SEL_EXT_CTRL, 64'h0, F_NONE, 64'h1);
		@(posedge i_ref_clk);
		i_exempt <= 1'b1;
		req(OP_SIMD_EXEC, SEL_EXT_CTRL, 64'h0, F_NONE, 64'h0);
		end_test("disabled");
		@(posedge i_ref_clk);
		i_priv <= 1'b0;
		i_exempt <= 1'b0;
		req(OP_CR_WRITE, SEL_EXT_CTRL, 64'h4_6600, F_GP, 64'h0);
		@(posedge i_ref_clk);
		i_priv <= 1'b1;
		req(OP_CR_WRITE, SEL_EXT_CTRL, 64'h8000, F_GP, 64'h0);
		chk_flags(5'h00);
		req(OP_CR_WRITE, SEL_EXT_CTRL, 64'h4_6600, F_NONE, 64'h0);
		chk_flags(5'h1F);
		req(OP_CR_READ, SEL_EXT_CTRL, 64'h0, F_NONE, 64'h4_6600);
		end_test("control");
		req(OP_QUERY, SEL_LEAF1, 64'h0, F_NONE, 64'h0C00_0000);
		req(OP_QUERY, SEL_LEAF0D, 64'h0, F_NONE, 64'h3);
		req(OP_QUERY, SEL_EXT_CTRL, 64'h0, F_NONE, 64'h4_66FF);
		req(OP_SIMD_EXEC, SEL_EXT_CTRL, 64'h0, F_NONE, 64'h0);
		req(OP_SIMD_FPX, SEL_EXT_CTRL, 64'h0, F_XF, 64'h0);
		req(OP_LEGACY_SAVE, SEL_EXT_CTRL, 64'h0, F_NONE, 64'h3);
		end_test("enabled");
		req(OP_MASK_WRITE, SEL_EXT_CTRL, 64'h3, F_NONE, 64'h0);
		chk(o_state_enable_mask, 64'h3);
		req(OP_MASK_WRITE, SEL_EXT_CTRL, 64'h2, F_GP, 64'h0);
		req(OP_MASK_WRITE, SEL_EXT_CTRL, 64'h8000_0000_0000_0003, F_GP, 64'h0);
		req(OP_MASK_WRITE, SEL_EXT_CTRL, 64'h7, F_GP, 64'h0);
		@(posedge i_ref_clk);
		i_priv <= 1'b0;
		req(OP_MASK_WRITE, SEL_EXT_CTRL, 64'h1, F_GP, 64'h0);
		req(OP_MASK_READ, SEL_EXT_CTRL, 64'h0, F_NONE, 64'h3);
		req(OP_EXT_SAVE, SEL_EXT_CTRL, 64'hFFFF_FFFF_FFFF_FFFF, F_NONE, 64'h3);
		req(OP_EXT_SAVE, SEL_EXT_CTRL, 64'h2, F_NONE, 64'h2);
		@(posedge i_ref_clk);
		i_priv <= 1'b1;
		req(OP_MASK_WRITE, SEL_EXT_CTRL, 64'h1, F_NONE, 64'h0);
		req(OP_EXT_SAVE, SEL_EXT_CTRL, 64'h3, F_NONE, 64'h1);
		end_test("mask");
		req(OP_CR_WRITE, SEL_TASK_PRIO, 64'hF, F_UD, 64'h0);
		@(posedge i_ref_clk);
		i_long_mode <= 1'b1;
		i_int_class <= 4'h5;
		req(OP_CR_WRITE, SEL_TASK_PRIO, 64'h10, F_GP, 64'h0);
		chk(64'(o_int_blocked), 64'h0);
		req(OP_CR_WRITE, SEL_TASK_PRIO, 64'hF, F_NONE, 64'h0);
		chk(64'(o_priority_threshold), 64'hF);
		repeat (2) @(posedge i_ref_clk);
		#1;
		chk(64'(o_int_blocked), 64'h1);
		chk(64'(o_vec_count), 64'h10);
		req(OP_CR_READ, SEL_TASK_PRIO, 64'h0, F_NONE, 64'hF);
		@(posedge i_ref_clk);
		i_int_class <= 4'hF;
		req(OP_CR_WRITE, SEL_TASK_PRIO, 64'h0, F_NONE, 64'h0);
		repeat (2) @(posedge i_ref_clk);
		#1;
		chk(64'(o_int_blocked), 64'h0);
		end_test("priority");
		req(OP_MASK_WRITE, SEL_EXT_CTRL, 64'h3, F_NONE, 64'h0);
		@(posedge i_ref_clk);
		i_reset_n <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
		i_reset_n <= 1'b1;
		@(posedge i_ref_clk);
		#1;
		chk(o_state_enable_mask, 64'h1);
		chk_flags(5'h00);
		chk(64'(o_priority_threshold), 64'h0);
		req(OP_EXT_SAVE, SEL_EXT_CTRL, 64'h3, F_UD, 64'h0);
		end_test("second reset");
		report_and_stop();
	end
endmodule : esc_ctrl_tb
`default_nettype wire
